// ===== rtl/tsef_div.v
// Iterative restoring divider, one quotient bit per clock.
// Assumes start only while idle; divisor of zero gives all ones.
`timescale 1ns/1ps
module tsef_div #(
    parameter W = 24
) (
    input wire pclk,
    input wire presetn,
    input wire start,
    input wire [W-1:0] num,
    input wire [W-1:0] den,
    output reg [W-1:0] quo_q,
    output reg done_q
);
    localparam [5:0] NBITS = W;
    reg [W-1:0] rem_q;
    reg [W-1:0] den_q;
    reg [W-1:0] n_q;
    reg [5:0] cnt_q;
    reg busy_q;
    wire [W:0] trial = {rem_q, n_q[W-1]} - {1'b0, den_q};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_q <= {W{1'b0}};
            den_q <= {W{1'b0}};
            n_q <= {W{1'b0}};
            quo_q <= {W{1'b0}};
            cnt_q <= 6'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                rem_q <= {W{1'b0}};
                den_q <= den;
                n_q <= num;
                cnt_q <= NBITS;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (!trial[W]) begin
                    rem_q <= trial[W-1:0];
                end else begin
                    rem_q <= {rem_q[W-2:0], n_q[W-1]};
                end
                quo_q <= {quo_q[W-2:0], ~trial[W]};
                n_q <= {n_q[W-2:0], 1'b0};
                cnt_q <= cnt_q - 6'h01;
                if (cnt_q == 6'h01) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== rtl/tsef_map.vh
// Register map, codes and timing constants of the third-harmonic stage.
// Assumes a 20 MHz pclk and a 32-bit APB register bus.
`ifndef TSEF_MAP_VH
`define TSEF_MAP_VH
// ****************************************
// Timing
// ****************************************
`define TSEF_TICK_US 5000
`define TSEF_CLK_MHZ 20
// ****************************************
// Register offsets
// ****************************************
`define TSEF_A_CTRL 8'h00
`define TSEF_A_G0_USET 8'h04
`define TSEF_A_G0_ILIM 8'h08
`define TSEF_A_G1_USET 8'h0c
`define TSEF_A_G1_ILIM 8'h10
`define TSEF_A_DELAY 8'h14
`define TSEF_A_UNPRI 8'h18
`define TSEF_A_GAP 8'h1c
`define TSEF_A_STATUS 8'h20
`define TSEF_A_RATIO 8'h24
`define TSEF_A_MEASPCT 8'h28
`define TSEF_A_MEASPRI 8'h2c
`define TSEF_A_THRV 8'h30
`define TSEF_A_TREM 8'h34
`define TSEF_A_TOP 8'h38
`define TSEF_A_IRQST 8'h3c
`define TSEF_A_IRQMSK 8'h40
// ****************************************
// Reset values
// ****************************************
`define TSEF_R_CTRL 11'h000
`define TSEF_R_USET 14'h07d0
`define TSEF_R_ILIM 14'h0000
`define TSEF_R_DELAY 19'h00008
`define TSEF_R_UNPRI 16'h1770
// ****************************************
// Codes and scaling
// ****************************************
`define TSEF_M_ON 3'h0
`define TSEF_M_BLK 3'h1
`define TSEF_M_TEST 3'h2
`define TSEF_M_TBLK 3'h3
`define TSEF_M_OFF 3'h4
`define TSEF_C_NORM 2'h0
`define TSEF_C_START 2'h1
`define TSEF_C_TRIP 2'h2
`define TSEF_C_BLKD 2'h3
`define TSEF_CH_NONE 2'h0
`define TSEF_CH_A 2'h1
`define TSEF_CH_B 2'h2
`define TSEF_HYST_PCT 7'h67
`define TSEF_PCT 7'h64
`define TSEF_RATIO_MAX 17'h1e848
`define TSEF_THRV_DIV 10'h3e8
`endif

// ===== rtl/tsef_seqcur.v
// Positive-sequence current estimate from three phase magnitudes.
// Assumes magnitudes in 0.01 x In steps, refreshed by the caller.
`timescale 1ns/1ps
module tsef_seqcur #(
    parameter W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire load,
    input wire [W-1:0] i_a,
    input wire [W-1:0] i_b,
    input wire [W-1:0] i_c,
    output reg [W-1:0] i_pos_q
);
    // Magnitudes only: exact for a balanced set, a limitation for unbalance
    wire [W+1:0] sum = {2'b00, i_a} + {2'b00, i_b} + {2'b00, i_c};
    wire [W+1:0] mean = sum / {{W{1'b0}}, 2'b11};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            i_pos_q <= {W{1'b0}};
        end else if (load) begin
            i_pos_q <= mean[W-1:0];
        end
    end
endmodule

// ===== rtl/tsef_stage.v
// Third-harmonic neutral under-voltage stage with APB registers.
// Assumes synchronous front-end inputs and block input on pclk.
//
// Contract
// - Latch both neutral third harmonics and phase currents every 5 ms.
// - Derive positive-sequence current from the three fundamental currents.
// - Source select picks channel A, B or unselected; unselected default.
// - Report channel in use: A, B or no neutral input available.
// - Pick up when voltage falls below threshold; default 20 percent.
// - Release only above 103 percent of threshold.
// - Nonzero current limit permits trip only above it; zero disables.
// - Report measured to threshold ratio, 0.00 to 1250.00.
// - Stage mode On, Blocked, Test, Test/Blocked, Off; gated globally.
// - Forced status Normal, Start, Trip, Blocked; gated globally.
// - Mode and force static; pick-up values follow active setting group.
// - Expose condition and effective operating mode.
// - Report remaining and expected operating time in 5 ms steps.
// - Report threshold in volts with 0.1 V resolution.
// - Report measurement as percent and primary volts, 0.01 resolution.
// - Sample block every 5 ms tick; blocked pick-up gives Blocked, else Start.
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "tsef_map.vh"
module tsef_stage #(
    parameter TICK_CYC = `TSEF_TICK_US * `TSEF_CLK_MHZ,
    parameter VW = 14,
    parameter IW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [VW-1:0] neutral_channel_a,
    input wire [VW-1:0] neutral_channel_b,
    input wire [IW-1:0] phase_i_a,
    input wire [IW-1:0] phase_i_b,
    input wire [IW-1:0] phase_i_c,
    input wire block_in,
    input wire group_sel,
    output reg start_o,
    output reg trip_o,
    output reg blocked_o,
    output reg irq
);
    // Sized tick length minus one, the counter's last value, for the compare
    localparam [16:0] TICK_LAST = TICK_CYC - 1;
    // ****************************************
    // Registers
    // ****************************************
    reg [10:0] ctrl_q;
    reg [VW-1:0] uset_q [0:1];
    reg [IW-1:0] ilim_q [0:1];
    reg [18:0] delay_q;
    reg [15:0] unpri_q;
    reg [3:0] ist_q;
    reg [3:0] imsk_q;
    reg [16:0] tick_cnt_q;
    reg tick_q;
    reg eval_q;
    reg [VW-1:0] va_q;
    reg [VW-1:0] vb_q;
    reg blk_s_q;
    reg pickup_q;
    reg [1:0] state_q;
    reg [18:0] tmr_q;
    reg [16:0] ratio_q;
    reg [29:0] meas_pri_q;
    reg [29:0] thrv_q;
    reg [19:0] trem_q;
    wire [IW-1:0] i_pos;
    wire [23:0] quo;
    wire div_done;
    integer k;
    // ****************************************
    // Decoding
    // ****************************************
    wire [2:0] mode_set = ctrl_q[2:0];
    wire [1:0] force_set = ctrl_q[4:3];
    wire [1:0] src_sel = ctrl_q[6:5];
    wire allow_mode = ctrl_q[7];
    wire allow_force = ctrl_q[8];
    wire role_a = ctrl_q[9];
    wire role_b = ctrl_q[10];
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    function [1:0] pick_chan;
        input ra;
        input rb;
        input [1:0] sel;
        begin
            if (ra && rb) begin
                pick_chan = (sel == `TSEF_CH_A || sel == `TSEF_CH_B) ? sel : `TSEF_CH_NONE;
            end else if (ra) begin
                pick_chan = `TSEF_CH_A;
            end else if (rb) begin
                pick_chan = `TSEF_CH_B;
            end else begin
                pick_chan = `TSEF_CH_NONE;
            end
        end
    endfunction
    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a[1:0] == 2'b00) && (a <= `TSEF_A_IRQMSK) && (a != `TSEF_A_GAP);
        end
    endfunction
    wire [1:0] chan = pick_chan(role_a, role_b, src_sel);
    // Mode and force are held off the setting groups
    wire [2:0] mode_eff = allow_mode ? mode_set : `TSEF_M_ON;
    wire [1:0] force_eff = allow_force ? force_set : `TSEF_C_NORM;
    wire [VW-1:0] uset = uset_q[group_sel];
    wire [IW-1:0] ilim = ilim_q[group_sel];
    wire [VW-1:0] vmeas = (chan == `TSEF_CH_B) ? vb_q : va_q;
    // Operands widened first, so no product loses its top bits
    wire [22:0] vmeas_23 = {{(23-VW){1'b0}}, vmeas};
    wire [22:0] uset_23 = {{(23-VW){1'b0}}, uset};
    wire [22:0] v_x100 = vmeas_23 * `TSEF_PCT;
    wire [22:0] u_x100 = uset_23 * `TSEF_PCT;
    wire [22:0] u_x103 = uset_23 * `TSEF_HYST_PCT;
    wire [29:0] unpri_30 = {14'h0000, unpri_q};
    wire [29:0] meas_prod = {{(30-VW){1'b0}}, vmeas} * unpri_30;
    wire [29:0] thr_prod = {{(30-VW){1'b0}}, uset} * unpri_30;
    wire [23:0] ratio_cap = {7'h00, `TSEF_RATIO_MAX};
    // Zero-extended read values
    wire [31:0] rd_vmeas = {{(32-VW){1'b0}}, vmeas};
    wire [31:0] rd_uset0 = {{(32-VW){1'b0}}, uset_q[0]};
    wire [31:0] rd_uset1 = {{(32-VW){1'b0}}, uset_q[1]};
    wire [31:0] rd_ilim0 = {{(32-IW){1'b0}}, ilim_q[0]};
    wire [31:0] rd_ilim1 = {{(32-IW){1'b0}}, ilim_q[1]};
    wire [31:0] rd_delay = {13'h0000, delay_q};
    wire permit = (ilim == {IW{1'b0}}) || (i_pos > ilim);
    wire blk = blk_s_q || mode_eff == `TSEF_M_BLK || mode_eff == `TSEF_M_TBLK;
    wire run = (mode_eff != `TSEF_M_OFF) && (chan != `TSEF_CH_NONE);
    wire test = mode_eff == `TSEF_M_TEST || mode_eff == `TSEF_M_TBLK;
    wire [1:0] cond = (force_eff != `TSEF_C_NORM) ? force_eff : state_q;
    // ****************************************
    // Processing tick
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 17'h00000;
            tick_q <= 1'b0;
            eval_q <= 1'b0;
            va_q <= {VW{1'b0}};
            vb_q <= {VW{1'b0}};
            blk_s_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_LAST);
            tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 17'h00000 : tick_cnt_q + 17'h00001;
            eval_q <= tick_q;
            if (tick_q) begin
                va_q <= neutral_channel_a;
                vb_q <= neutral_channel_b;
                blk_s_q <= block_in;
            end
        end
    end
    tsef_seqcur #(.W(IW)) u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .load(tick_q),
        .i_a(phase_i_a),
        .i_b(phase_i_b),
        .i_c(phase_i_c),
        .i_pos_q(i_pos)
    );
    tsef_div #(.W(24)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(eval_q),
        .num({1'b0, v_x100}),
        .den({10'h000, uset}),
        .quo_q(quo),
        .done_q(div_done)
    );
    // ****************************************
    // Pick-up, timing and condition
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pickup_q <= 1'b0;
            state_q <= `TSEF_C_NORM;
            tmr_q <= 19'h00000;
        end else if (eval_q) begin
            if (!run) begin
                pickup_q <= 1'b0;
            end else if (!pickup_q && v_x100 < u_x100) begin
                pickup_q <= 1'b1;
            end else if (pickup_q && v_x100 > u_x103) begin
                pickup_q <= 1'b0;
            end
            if (!run || !pickup_q) begin
                state_q <= `TSEF_C_NORM;
                tmr_q <= 19'h00000;
            end else begin
                case (state_q)
                    `TSEF_C_NORM: begin
                        // Blocked at pick-up stays blocked until release
                        state_q <= blk ? `TSEF_C_BLKD : `TSEF_C_START;
                        tmr_q <= 19'h00000;
                    end
                    `TSEF_C_START: begin
                        if (blk) begin
                            state_q <= `TSEF_C_BLKD;
                            tmr_q <= 19'h00000;
                        end else begin
                            if (tmr_q < delay_q) begin
                                tmr_q <= tmr_q + 19'h00001;
                            end
                            if (tmr_q + 19'h00001 >= delay_q && permit) begin
                                state_q <= `TSEF_C_TRIP;
                            end
                        end
                    end
                    `TSEF_C_TRIP: begin
                        if (blk || !permit) begin
                            state_q <= blk ? `TSEF_C_BLKD : `TSEF_C_START;
                        end
                    end
                    default: begin
                        state_q <= `TSEF_C_BLKD;
                    end
                endcase
            end
        end
    end
    // ****************************************
    // Reported values
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ratio_q <= 17'h00000;
            meas_pri_q <= 30'h00000000;
            thrv_q <= 30'h00000000;
            trem_q <= 20'h00000;
            start_o <= 1'b0;
            trip_o <= 1'b0;
            blocked_o <= 1'b0;
        end else begin
            if (div_done) begin
                // Clamp keeps a tiny threshold from wrapping
                ratio_q <= (quo > ratio_cap) ? `TSEF_RATIO_MAX : quo[16:0];
            end
            meas_pri_q <= meas_prod / `TSEF_PCT;
            thrv_q <= thr_prod / `TSEF_THRV_DIV;
            trem_q <= (state_q == `TSEF_C_START) ?
                ({1'b0, delay_q} - {1'b0, tmr_q}) : 20'h00000;
            // Test modes report but keep start_o and trip_o quiet
            start_o <= !test && (cond == `TSEF_C_START || cond == `TSEF_C_TRIP);
            trip_o <= !test && cond == `TSEF_C_TRIP;
            blocked_o <= cond == `TSEF_C_BLKD;
        end
    end
    // ****************************************
    // Events and interrupt
    // ****************************************
    reg [1:0] cond_prev_q;
    wire [3:0] ev;
    assign ev[0] = cond == `TSEF_C_START && cond_prev_q != `TSEF_C_START;
    assign ev[1] = cond == `TSEF_C_TRIP && cond_prev_q != `TSEF_C_TRIP;
    assign ev[2] = cond == `TSEF_C_BLKD && cond_prev_q != `TSEF_C_BLKD;
    assign ev[3] = cond == `TSEF_C_NORM && cond_prev_q != `TSEF_C_NORM;
    wire ist_rd = rd && paddr == `TSEF_A_IRQST;
    // Clear only what the read returned; later events stay pending
    wire [3:0] ist_clr = ist_rd ? prdata[3:0] : 4'h0;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_prev_q <= `TSEF_C_NORM;
            ist_q <= 4'h0;
            irq <= 1'b0;
        end else begin
            cond_prev_q <= cond;
            // A new event in the clearing read's cycle survives
            ist_q <= (ist_q & ~ist_clr) | ev;
            irq <= |(((ist_q & ~ist_clr) | ev) & imsk_q);
        end
    end
    // ****************************************
    // APB slave, one wait state
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TSEF_R_CTRL;
            for (k = 0; k < 2; k = k + 1) begin
                uset_q[k] <= `TSEF_R_USET;
                ilim_q[k] <= `TSEF_R_ILIM;
            end
            delay_q <= `TSEF_R_DELAY;
            unpri_q <= `TSEF_R_UNPRI;
            imsk_q <= 4'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_ok(paddr);
            if (psel && penable && !pready) begin
                case (paddr)
                    `TSEF_A_CTRL: prdata <= {21'h000000, ctrl_q};
                    `TSEF_A_G0_USET: prdata <= rd_uset0;
                    `TSEF_A_G0_ILIM: prdata <= rd_ilim0;
                    `TSEF_A_G1_USET: prdata <= rd_uset1;
                    `TSEF_A_G1_ILIM: prdata <= rd_ilim1;
                    `TSEF_A_DELAY: prdata <= rd_delay;
                    `TSEF_A_UNPRI: prdata <= {16'h0000, unpri_q};
                    `TSEF_A_STATUS: prdata <= {23'h000000, permit, pickup_q,
                        chan, mode_eff, cond};
                    `TSEF_A_RATIO: prdata <= {15'h0000, ratio_q};
                    `TSEF_A_MEASPCT: prdata <= rd_vmeas;
                    `TSEF_A_MEASPRI: prdata <= {2'h0, meas_pri_q};
                    `TSEF_A_THRV: prdata <= {2'h0, thrv_q};
                    `TSEF_A_TREM: prdata <= {{12{trem_q[19]}}, trem_q};
                    `TSEF_A_TOP: prdata <= rd_delay;
                    `TSEF_A_IRQST: prdata <= {28'h0000000, ist_q};
                    `TSEF_A_IRQMSK: prdata <= {28'h0000000, imsk_q};
                    default: prdata <= 32'h00000000;
                endcase
            end
            if (wr) begin
                case (paddr)
                    `TSEF_A_CTRL: ctrl_q <= pwdata[10:0];
                    `TSEF_A_G0_USET: uset_q[0] <= pwdata[VW-1:0];
                    `TSEF_A_G0_ILIM: ilim_q[0] <= pwdata[IW-1:0];
                    `TSEF_A_G1_USET: uset_q[1] <= pwdata[VW-1:0];
                    `TSEF_A_G1_ILIM: ilim_q[1] <= pwdata[IW-1:0];
                    `TSEF_A_DELAY: delay_q <= pwdata[18:0];
                    `TSEF_A_UNPRI: unpri_q <= pwdata[15:0];
                    `TSEF_A_IRQMSK: imsk_q <= pwdata[3:0];
                    default: imsk_q <= imsk_q;
                endcase
            end
        end
    end
endmodule

// ===== sim/tsef_front_model.sv
// Front-end model: neutral levels, phase currents and block input.
// Assumes the bench sets targets; TICK equals the stage tick.
`timescale 1ns/1ps
module tsef_front_model #(
    parameter TICK = 20
) (
    input wire pclk,
    input wire presetn,
    input wire [13:0] ua_set,
    input wire [13:0] ub_set,
    input wire [47:0] i_set,
    input wire blk_set,
    output reg [13:0] u_a,
    output reg [13:0] u_b,
    output reg [47:0] i_abc,
    output reg blk
);
    reg [15:0] cnt_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0;
            u_a <= 14'h0;
            u_b <= 14'h0;
            i_abc <= 48'h0;
            blk <= 1'b0;
        end else begin
            cnt_q <= (cnt_q == TICK - 1) ? 16'h0 : cnt_q + 16'h1;
            if (cnt_q == TICK - 1) begin
                u_a <= ua_set;
                u_b <= ub_set;
                i_abc <= i_set;
            end
            // Passed at once, so it always leads the operate delay
            blk <= blk_set;
        end
    end
endmodule

// ===== sim/tsef_stage_properties.sv
// Checker for the stage's bus handshake and condition outputs.
// Assumes it is bound onto tsef_stage and sees only its ports.
`timescale 1ns/1ps
module tsef_stage_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire start_o,
    input wire trip_o,
    input wire blocked_o,
    input wire irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire bad_a = (paddr[1:0] != 2'h0) || (paddr > 8'h40) || (paddr == 8'h1c);
    wire done = psel && penable && pready;
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not after one wait state");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_bad_refused: assert property (done && bad_a |-> pslverr && prdata == 32'h0)
        else $error("bad address not refused");
    a_good_taken: assert property (done && !bad_a |-> !pslverr)
        else $error("mapped address refused");
    a_trip_start: assert property (trip_o |-> start_o)
        else $error("trip without start");
    a_blocked_alone: assert property (blocked_o |-> !start_o && !trip_o)
        else $error("blocked with start or trip");
    a_reset_quiet: assert property ($rose(presetn) |-> !start_o && !trip_o && !irq)
        else $error("outputs active after reset");
    c_refused: cover property (done && bad_a);
    c_trip: cover property (trip_o);
    c_blocked: cover property (blocked_o);
    c_irq: cover property (irq);
endmodule
bind tsef_stage tsef_stage_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .irq(irq));

// ===== sim/tsef_stage_tb.sv
// Bench: APB tasks and sequences of register calls on the stage.
// Assumes TICK_CYC of 20 and the front-end model on the far side.
`timescale 1ns/1ps
`include "tsef_map.vh"
module tsef_stage_tb;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg [13:0] ua_set = 14'h0;
    reg [13:0] ub_set = 14'h0;
    reg [47:0] i_set = 48'h0;
    reg blk_set = 1'b0;
    reg group_sel = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, start_o, trip_o, blocked_o, irq, blk;
    wire [13:0] u_a, u_b;
    wire [47:0] i_abc;
    reg [31:0] rd;
    reg slv;
    integer err_count = 0;
    integer n_checks = 0;
    integer k;
    always #25 pclk = ~pclk;
    tsef_stage #(.TICK_CYC(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .neutral_channel_a(u_a),
        .neutral_channel_b(u_b), .phase_i_a(i_abc[15:0]), .phase_i_b(i_abc[31:16]),
        .phase_i_c(i_abc[47:32]), .block_in(blk), .group_sel(group_sel),
        .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .irq(irq));
    tsef_front_model #(.TICK(20)) model_u (.pclk(pclk), .presetn(presetn), .ua_set(ua_set),
        .ub_set(ub_set), .i_set(i_set), .blk_set(blk_set), .u_a(u_a), .u_b(u_b),
        .i_abc(i_abc), .blk(blk));
    // ****************************************
    // Tasks
    // ****************************************
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("Error %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    // Waits an edge first, so back-to-back calls never drive twice at once
    task apb(input wr, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 50);
            if (pready !== 1'b1) err_count = err_count + 1;
            rd = prdata;
            slv = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd_chk(input [7:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            check($sformatf("reg %h", a), rd, exp);
        end
    endtask
    task ticks(input integer n);
        begin
            repeat (n * 20) @(posedge pclk);
        end
    endtask
    task stop_test;
        begin
            $display("Counts: %0d checks, %0d mismatches", n_checks, err_count);
            if (err_count == 0 && n_checks > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (40000) @(posedge pclk);
        err_count = err_count + 1;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`TSEF_A_CTRL, 32'h0);
        rd_chk(`TSEF_A_G0_USET, 32'h7d0);
        rd_chk(`TSEF_A_G0_ILIM, 32'h0);
        rd_chk(`TSEF_A_TOP, 32'h8);
        rd_chk(`TSEF_A_THRV, 32'h2ee0);
        rd_chk(`TSEF_A_STATUS, 32'h100);
        rd_chk(8'h1c, 32'h0);
        check("slverr", slv, 1'b1);
        apb(1'b1, 8'h44, 32'h1);
        check("slverr", slv, 1'b1);
        $display("Test reset done");
        // Mean current equal to the limit must not permit a trip
        ua_set <= 14'h3e8;
        i_set <= {16'h258, 16'h1f4, 16'h190};
        wr_all();
        ticks(8);
        rd_chk(`TSEF_A_STATUS, 32'ha1);
        check("trip_o", trip_o, 1'b0);
        i_set <= {16'h320, 16'h258, 16'h190};
        ticks(6);
        check("trip_o", trip_o, 1'b1);
        rd_chk(`TSEF_A_RATIO, 32'h32);
        rd_chk(`TSEF_A_MEASPCT, 32'h3e8);
        rd_chk(`TSEF_A_MEASPRI, 32'hea60);
        check("irq", irq, 1'b1);
        rd_chk(`TSEF_A_IRQST, 32'h3);
        repeat (2) @(posedge pclk);
        check("irq", irq, 1'b0);
        $display("Test trip done");
        apb(1'b1, `TSEF_A_IRQMSK, 32'h0);
        ua_set <= 14'h802;
        ticks(4);
        check("trip_o", trip_o, 1'b1);
        ua_set <= 14'h816;
        ticks(4);
        check("start_o", start_o, 1'b0);
        check("irq", irq, 1'b0);
        rd_chk(`TSEF_A_IRQST, 32'h8);
        $display("Test release done");
        group_sel <= 1'b1;
        apb(1'b1, `TSEF_A_G1_USET, 32'h1f4);
        rd_chk(`TSEF_A_THRV, 32'hbb8);
        ua_set <= 14'h3e8;
        ticks(4);
        check("start_o", start_o, 1'b0);
        group_sel <= 1'b0;
        ticks(4);
        check("start_o", start_o, 1'b1);
        ua_set <= 14'h9c4;
        blk_set <= 1'b1;
        ticks(4);
        ua_set <= 14'h3e8;
        ticks(4);
        check("blocked_o", blocked_o, 1'b1);
        blk_set <= 1'b0;
        ua_set <= 14'h9c4;
        ticks(4);
        $display("Test group and block done");
        for (k = 0; k < 5; k = k + 1) begin
            apb(1'b1, `TSEF_A_CTRL, 32'h2a0 | k);
            ticks(2);
            apb(1'b0, `TSEF_A_STATUS, 32'h0);
            check("mode", rd[4:2], k);
        end
        ua_set <= 14'h3e8;
        ticks(4);
        check("start_o", start_o, 1'b0);
        apb(1'b1, `TSEF_A_CTRL, 32'h2a2);
        ticks(8);
        apb(1'b0, `TSEF_A_STATUS, 32'h0);
        check("cond", rd[1:0], `TSEF_C_TRIP);
        check("trip_o", trip_o, 1'b0);
        apb(1'b1, `TSEF_A_CTRL, 32'h224);
        ticks(2);
        apb(1'b0, `TSEF_A_STATUS, 32'h0);
        check("mode", rd[4:2], `TSEF_M_ON);
        ua_set <= 14'h9c4;
        for (k = 0; k < 4; k = k + 1) begin
            apb(1'b1, `TSEF_A_CTRL, 32'h320 | (k << 3));
            ticks(2);
            apb(1'b0, `TSEF_A_STATUS, 32'h0);
            check("cond", rd[1:0], k);
        end
        ub_set <= 14'h3e8;
        apb(1'b1, `TSEF_A_CTRL, 32'h640);
        ticks(8);
        apb(1'b0, `TSEF_A_STATUS, 32'h0);
        check("chan", rd[6:5], `TSEF_CH_B);
        check("trip_o", trip_o, 1'b1);
        apb(1'b1, `TSEF_A_CTRL, 32'h600);
        apb(1'b0, `TSEF_A_STATUS, 32'h0);
        check("chan", rd[6:5], `TSEF_CH_NONE);
        $display("Test modes and channels done");
        stop_test;
    end
    task wr_all;
        begin
            apb(1'b1, `TSEF_A_IRQMSK, 32'hf);
            apb(1'b1, `TSEF_A_DELAY, 32'h2);
            apb(1'b1, `TSEF_A_G0_ILIM, 32'h1f4);
            apb(1'b1, `TSEF_A_CTRL, 32'h220);
        end
    endtask
endmodule
